//--- logic/mdpc_regs.sv
/*
  Protection and regulator configuration register bank with a small
  overcurrent filter and fault handler that the fields steer.
  Assumes the serial port framing sits outside and presents one write or
  read per cycle; all inputs but the asynchronous reset resetn_i are synchronous to clk_i.
*/
// How it works
// - shutoff bit one requests standby, zero idle
// - cycle clear bit clears overcurrent per PWM
// - filter field picks deglitch time, resets one
// - retry bit picks 5 ms or 500 ms
// - threshold bit picks 16 A or 24 A
// - response zero latches fault until cleared
// - response one recovers after retry time
// - response two reports only, three ignores
// - recirculation bit picks transistors or diodes
// - bit three enables asynchronous active rectification
// - bit two enables synchronous active rectification
// - gain field selects sense amplifier gain
// - sequencing off bit disables regulator sequencing
// - cap bit picks 600 mA or 150 mA
// - voltage field selects regulator output voltage
// - regulator off bit disables regulator, resets zero
// - lock pattern blocks writes, unlock pattern reopens
// - fault clear clears latched faults, self clears
`timescale 1ns/100ps
`default_nettype none
module mdpc_regs
  import mdpc_pkg::*;
#(
  parameter int RETRY_SHORT = MDPC_RETRY0_CYC,
  parameter int RETRY_LONG  = MDPC_RETRY1_CYC
) (
  // Clock and reset.
  input  wire logic      clk_i,
  input  wire logic      resetn_i,
  // Register port.
  input  wire mdpc_wr_t  wr_i,
  input  wire logic      rd_i,
  output logic [7:0]     rdata_o,
  // Sensing inputs from the power stage.
  input  wire logic      oc_hi_i,
  input  wire logic      oc_lo_i,
  input  wire logic      pwm_i,
  // Configuration and fault outputs.
  output mdpc_cfg_t      cfg_o,
  output logic           standby_o,
  output logic           oc_shutdown_o,
  output logic           oc_report_o,
  output logic           locked_o
);

  // The wait counter is 28 bits wide, so longer counts cannot be served.
  if (RETRY_SHORT < 1 || RETRY_SHORT >= 2**28 ||
      RETRY_LONG < 1 || RETRY_LONG >= 2**28) begin : g_bad_retry
    $error("retry counts out of range");
  end

  mdpc_state_t st_ff;
  mdpc_state_t nxt_st;

  // Deglitch time in cycles for a filter code.
  function automatic logic [15:0] deg_cycles(input logic [1:0] code);
    unique case (code)
      2'h0:    deg_cycles = 16'(MDPC_DEG0_CYC);
      2'h1:    deg_cycles = 16'(MDPC_DEG1_CYC);
      2'h2:    deg_cycles = 16'(MDPC_DEG2_CYC);
      2'h3:    deg_cycles = 16'(MDPC_DEG3_CYC);
    endcase
  endfunction

  logic        wr_ok;
  logic        clr_hit;
  logic        oc_raw;
  logic        oc_seen;
  logic        pwm_edge;
  logic [1:0]  resp;
  logic [27:0] retry_len;

  // Trip level picks which comparator counts; mode and timing from fields.
  always_comb begin
    resp      = st_ff.ocp[1:0];
    oc_raw    = st_ff.ocp[MDPC_B_THRESH] ? oc_hi_i : oc_lo_i;
    retry_len = st_ff.ocp[MDPC_B_RETRY] ? 28'(RETRY_LONG)
                                        : 28'(RETRY_SHORT);
    pwm_edge  = pwm_i & ~st_ff.pwm_prev;
    oc_seen   = oc_raw && (st_ff.filt_cnt + 16'h0001 >=
                deg_cycles(st_ff.ocp[5:4]));
    // Writes pass only while unlocked, except the lock field itself.
    wr_ok     = wr_i.wr && !st_ff.locked;
    clr_hit   = wr_ok && wr_i.addr == MDPC_OFS_CLR &&
                wr_i.data[MDPC_B_FCLR];
  end

  // Next state of the whole bank.
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.pwm_prev = pwm_i;
    // Register writes land at once and steer logic next cycle.
    if (wr_ok) begin
      unique case (wr_i.addr)
        MDPC_OFS_OCP:  nxt_st.ocp  = wr_i.data;
        MDPC_OFS_RECT: nxt_st.rect = wr_i.data;
        MDPC_OFS_REG:  nxt_st.regc = wr_i.data & MDPC_REG_WMASK;
        default: ;
      endcase
    end
    if (wr_i.wr && wr_i.addr == MDPC_OFS_LOCK) begin
      if (wr_i.data[2:0] == MDPC_LOCK_ON) begin
        nxt_st.locked = 1'b1;
      end else if (wr_i.data[2:0] == MDPC_LOCK_OFF) begin
        nxt_st.locked = 1'b0;
      end
    end
    // Filter counts continuous overcurrent samples.
    if (!oc_raw) begin
      nxt_st.filt_cnt = 16'h0000;
    end else if (!oc_seen) begin
      nxt_st.filt_cnt = st_ff.filt_cnt + 16'h0001;
    end
    // Clearing first so a fresh detection in the same cycle wins.
    if (clr_hit) begin
      nxt_st.oc_fault  = 1'b0;
      nxt_st.oc_report = 1'b0;
    end
    if (st_ff.ocp[MDPC_B_CYCCLR] && pwm_edge) begin
      nxt_st.oc_fault = 1'b0;
    end
    if (st_ff.oc_fault && resp == MDPC_OC_RETRY) begin
      if (st_ff.retry_cnt + 28'h000_0001 >= retry_len) begin
        nxt_st.oc_fault  = 1'b0;
        nxt_st.retry_cnt = 28'h000_0000;
      end else begin
        nxt_st.retry_cnt = st_ff.retry_cnt + 28'h000_0001;
      end
    end
    if (oc_seen) begin
      unique case (resp)
        MDPC_OC_LATCH: begin
          nxt_st.oc_fault  = 1'b1;
          nxt_st.oc_report = 1'b1;
        end
        MDPC_OC_RETRY: begin
          nxt_st.oc_fault  = 1'b1;
          nxt_st.oc_report = 1'b1;
          nxt_st.retry_cnt = 28'h000_0000;
        end
        MDPC_OC_REPORT: nxt_st.oc_report = 1'b1;
        MDPC_OC_IGNORE: ;
      endcase
    end
    // Read data registered; unmapped offsets read zero.
    if (rd_i) begin
      unique case (wr_i.addr)
        MDPC_OFS_OCP:  nxt_st.rdata = st_ff.ocp;
        MDPC_OFS_RECT: nxt_st.rdata = st_ff.rect;
        MDPC_OFS_REG:  nxt_st.rdata = st_ff.regc & MDPC_REG_WMASK;
        MDPC_OFS_LOCK: nxt_st.rdata = {7'h00, st_ff.locked};
        default:       nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff      <= '0;
      st_ff.ocp  <= MDPC_RST_OCP;
      st_ff.rect <= MDPC_RST_RECT;
      st_ff.regc <= MDPC_RST_REG;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Decoded fields straight from the registers.
  always_comb begin
    cfg_o.shutoff      = st_ff.ocp[MDPC_B_SHUTOFF];
    cfg_o.cycle_clear  = st_ff.ocp[MDPC_B_CYCCLR];
    cfg_o.filter_time  = st_ff.ocp[5:4];
    cfg_o.retry_long   = st_ff.ocp[MDPC_B_RETRY];
    cfg_o.threshold_hi = st_ff.ocp[MDPC_B_THRESH];
    cfg_o.response     = st_ff.ocp[1:0];
    cfg_o.recirc_diode = st_ff.rect[MDPC_B_RECIRC];
    cfg_o.async_rect   = st_ff.rect[MDPC_B_AAR];
    cfg_o.sync_rect    = st_ff.rect[MDPC_B_ASR];
    cfg_o.gain         = st_ff.rect[1:0];
    cfg_o.seq_off      = st_ff.regc[MDPC_B_SEQOFF];
    cfg_o.cap_low      = st_ff.regc[MDPC_B_CAP];
    cfg_o.voltage      = st_ff.regc[2:1];
    cfg_o.reg_off      = st_ff.regc[MDPC_B_REGOFF];
  end

  assign standby_o     = st_ff.ocp[MDPC_B_SHUTOFF];
  assign oc_shutdown_o = st_ff.oc_fault;
  assign oc_report_o   = st_ff.oc_report;
  assign locked_o      = st_ff.locked;
  assign rdata_o       = st_ff.rdata;

  // Checks.
  property p_lock_blocks;
    @(posedge clk_i) disable iff (!resetn_i)
      (st_ff.locked && wr_i.wr && wr_i.addr == MDPC_OFS_OCP)
      |=> $stable(st_ff.ocp);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("locked write changed a register");

  property p_write_lands;
    @(posedge clk_i) disable iff (!resetn_i)
      (!st_ff.locked && wr_i.wr && wr_i.addr == MDPC_OFS_RECT)
      |=> cfg_o.gain == $past(wr_i.data[1:0]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write not visible next cycle");

  property p_resv_zero;
    @(posedge clk_i) disable iff (!resetn_i) st_ff.regc[7:6] == 2'b00;
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved bits not zero");

  property p_latch_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      (oc_shutdown_o && resp == MDPC_OC_LATCH && !clr_hit &&
       !(cfg_o.cycle_clear && pwm_edge)) |=> oc_shutdown_o;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched fault dropped");

  property p_clear;
    @(posedge clk_i) disable iff (!resetn_i)
      (clr_hit && !oc_seen) |=> !oc_shutdown_o && !oc_report_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("fault clear ignored");

  property p_report_only;
    @(posedge clk_i) disable iff (!resetn_i)
      (oc_seen && resp == MDPC_OC_REPORT) |=> oc_report_o;
  endproperty
  a_report_only: assert property (p_report_only)
    else $error("report mode not reported");

  property p_ignore;
    @(posedge clk_i) disable iff (!resetn_i)
      (resp == MDPC_OC_IGNORE && !oc_report_o && !oc_shutdown_o)
      |=> !oc_shutdown_o;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ignore mode acted");

  property p_standby;
    @(posedge clk_i) disable iff (!resetn_i)
      (!st_ff.locked && wr_i.wr && wr_i.addr == MDPC_OFS_OCP)
      |=> standby_o == $past(wr_i.data[MDPC_B_SHUTOFF]);
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby mismatch");

  property p_cycle_clear;
    @(posedge clk_i) disable iff (!resetn_i)
      (cfg_o.cycle_clear && pwm_edge && !oc_seen) |=> !oc_shutdown_o;
  endproperty
  a_cycle_clear: assert property (p_cycle_clear)
    else $error("cycle clear missed");

  property p_glitch;
    @(posedge clk_i) disable iff (!resetn_i)
      !oc_raw |=> !oc_seen;
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("single sample passed the filter");

  property p_retry_wait;
    @(posedge clk_i) disable iff (!resetn_i)
      (oc_shutdown_o && resp == MDPC_OC_RETRY && !clr_hit &&
       !(cfg_o.cycle_clear && pwm_edge) &&
       st_ff.retry_cnt + 28'h000_0001 < retry_len) |=> oc_shutdown_o;
  endproperty
  a_retry_wait: assert property (p_retry_wait)
    else $error("retrying fault released early");

  property p_high_level;
    @(posedge clk_i) disable iff (!resetn_i)
      (cfg_o.threshold_hi && !oc_hi_i) |=> st_ff.filt_cnt == 16'h0000;
  endproperty
  a_high_level: assert property (p_high_level)
    else $error("low comparator counted at high level");

  property p_latch_trip;
    @(posedge clk_i) disable iff (!resetn_i)
      (oc_seen && resp == MDPC_OC_LATCH) |=> oc_shutdown_o && oc_report_o;
  endproperty
  a_latch_trip: assert property (p_latch_trip)
    else $error("latched fault not raised");

  property p_retry_trip;
    @(posedge clk_i) disable iff (!resetn_i)
      (oc_seen && resp == MDPC_OC_RETRY)
      |=> oc_shutdown_o && st_ff.retry_cnt == 28'h000_0000;
  endproperty
  a_retry_trip: assert property (p_retry_trip)
    else $error("retrying fault not raised");

  property p_report_no_act;
    @(posedge clk_i) disable iff (!resetn_i)
      (resp == MDPC_OC_REPORT && !oc_shutdown_o) |=> !oc_shutdown_o;
  endproperty
  a_report_no_act: assert property (p_report_no_act)
    else $error("report mode acted");

  property p_reg_write;
    @(posedge clk_i) disable iff (!resetn_i)
      (!st_ff.locked && wr_i.wr && wr_i.addr == MDPC_OFS_REG)
      |=> cfg_o.voltage == $past(wr_i.data[2:1]);
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("voltage field not taken");

  property p_lock_on;
    @(posedge clk_i) disable iff (!resetn_i)
      (wr_i.wr && wr_i.addr == MDPC_OFS_LOCK &&
       wr_i.data[2:0] == MDPC_LOCK_ON) |=> locked_o;
  endproperty
  a_lock_on: assert property (p_lock_on)
    else $error("lock pattern ignored");

  property p_unlock;
    @(posedge clk_i) disable iff (!resetn_i)
      (wr_i.wr && wr_i.addr == MDPC_OFS_LOCK &&
       wr_i.data[2:0] == MDPC_LOCK_OFF) |=> !locked_o;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock pattern ignored");

  property p_clear_not_stored;
    @(posedge clk_i) disable iff (!resetn_i)
      (rd_i && wr_i.addr == MDPC_OFS_CLR) |=> rdata_o == 8'h00;
  endproperty
  a_clear_not_stored: assert property (p_clear_not_stored)
    else $error("fault clear bit read back set");

endmodule
`default_nettype wire

//--- common/mdpc_pkg.sv
/*
  Package for the motor driver protection configuration register bank:
  offsets, field positions, reset values and timing constants.
  Assumes a single 200 MHz clock domain.
*/
package mdpc_pkg;

  // Register offsets.
  localparam logic [3:0] MDPC_OFS_LOCK = 4'h3;
  localparam logic [3:0] MDPC_OFS_CLR  = 4'h4;
  localparam logic [3:0] MDPC_OFS_OCP  = 4'h6;
  localparam logic [3:0] MDPC_OFS_RECT = 4'h7;
  localparam logic [3:0] MDPC_OFS_REG  = 4'h8;

  // Reset values.
  localparam logic [7:0] MDPC_RST_OCP  = 8'h10;
  localparam logic [7:0] MDPC_RST_RECT = 8'h00;
  localparam logic [7:0] MDPC_RST_REG  = 8'h00;

  // Lock field patterns and write masks.
  localparam logic [2:0] MDPC_LOCK_ON   = 3'h6;
  localparam logic [2:0] MDPC_LOCK_OFF  = 3'h3;
  localparam logic [7:0] MDPC_REG_WMASK = 8'h3f;

  // Field positions.
  localparam int MDPC_B_SHUTOFF   = 7;
  localparam int MDPC_B_CYCCLR    = 6;
  localparam int MDPC_B_RETRY     = 3;
  localparam int MDPC_B_THRESH    = 2;
  localparam int MDPC_B_RECIRC    = 6;
  localparam int MDPC_B_AAR       = 3;
  localparam int MDPC_B_ASR       = 2;
  localparam int MDPC_B_SEQOFF    = 4;
  localparam int MDPC_B_CAP       = 3;
  localparam int MDPC_B_REGOFF    = 0;
  localparam int MDPC_B_FCLR      = 0;

  // Timing: clock period and the filter and retry times.
  localparam int MDPC_CLK_PS      = 5000;
  localparam int MDPC_DEG0_PS     = 200000;
  localparam int MDPC_DEG1_PS     = 600000;
  localparam int MDPC_DEG2_PS     = 1250000;
  localparam int MDPC_DEG3_PS     = 1600000;
  localparam int MDPC_RETRY0_MS   = 5;
  localparam int MDPC_RETRY1_MS   = 500;
  localparam int MDPC_DEG0_CYC    = MDPC_DEG0_PS / MDPC_CLK_PS;
  localparam int MDPC_DEG1_CYC    = MDPC_DEG1_PS / MDPC_CLK_PS;
  localparam int MDPC_DEG2_CYC    = MDPC_DEG2_PS / MDPC_CLK_PS;
  localparam int MDPC_DEG3_CYC    = MDPC_DEG3_PS / MDPC_CLK_PS;
  localparam int MDPC_RETRY0_CYC  = MDPC_RETRY0_MS * 200000;
  localparam int MDPC_RETRY1_CYC  = MDPC_RETRY1_MS * 200000;

  // Overcurrent response codes.
  typedef enum logic [1:0] {
    MDPC_OC_LATCH  = 2'h0,
    MDPC_OC_RETRY  = 2'h1,
    MDPC_OC_REPORT = 2'h2,
    MDPC_OC_IGNORE = 2'h3
  } mdpc_ocresp_t;

  // Register write port.
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] data;
  } mdpc_wr_t;

  // Decoded configuration for the protection and regulator logic.
  typedef struct packed {
    logic       shutoff;
    logic       cycle_clear;
    logic [1:0] filter_time;
    logic       retry_long;
    logic       threshold_hi;
    logic [1:0] response;
    logic       recirc_diode;
    logic       async_rect;
    logic       sync_rect;
    logic [1:0] gain;
    logic       seq_off;
    logic       cap_low;
    logic [1:0] voltage;
    logic       reg_off;
  } mdpc_cfg_t;

  // Full state of the bank.
  typedef struct packed {
    logic [7:0]  ocp;
    logic [7:0]  rect;
    logic [7:0]  regc;
    logic        locked;
    logic [7:0]  rdata;
    logic [15:0] filt_cnt;
    logic [27:0] retry_cnt;
    logic        oc_fault;
    logic        oc_report;
    logic        pwm_prev;
  } mdpc_state_t;

endpackage

//--- verification/tb_mdpc_regs.sv
/*
  Self-checking testbench for the protection configuration register bank.
  Assumes the bank's own assertions sit in the design file; this bench
  drives all ports directly, 1 ns after each rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_mdpc_regs;
  import mdpc_pkg::*;
  // Short retry counts keep the run brief.
  localparam int RS = 20;
  localparam int RL = 50;
  logic       clk_i    = 1'b0;
  logic       resetn_i = 1'b0;
  logic       rd_i     = 1'b0;
  logic       oc_hi_i  = 1'b0;
  logic       oc_lo_i  = 1'b0;
  logic       pwm_i    = 1'b0;
  mdpc_wr_t   wr_i     = '0;
  logic [7:0] rdata_o;
  mdpc_cfg_t  cfg_o;
  logic       standby_o;
  logic       oc_shutdown_o;
  logic       oc_report_o;
  logic       locked_o;
  int         fails      = 0;
  int         n_compared = 0;

  mdpc_regs #(.RETRY_SHORT(RS), .RETRY_LONG(RL)) i_mdpc_regs (
    .clk_i(clk_i), .resetn_i(resetn_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .oc_hi_i(oc_hi_i), .oc_lo_i(oc_lo_i),
    .pwm_i(pwm_i), .cfg_o(cfg_o), .standby_o(standby_o),
    .oc_shutdown_o(oc_shutdown_o), .oc_report_o(oc_report_o),
    .locked_o(locked_o)
  );

  // A 200 MHz clock.
  always #2.5 clk_i = ~clk_i;

  // Compares one value and counts the outcome.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits n edges and steps 1 ns past the last, where inputs change.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One write pulse, then one idle edge, so that a following call never
  // raises the strobe in the same step that lowered it.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_i = '{1'b1, a, d};
    cyc(1);
    wr_i.wr = 1'b0;
    cyc(1);
  endtask

  // One read pulse; data stands from the taking edge until the next read.
  // An idle edge follows so back-to-back reads keep the strobe clean.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wr_i.addr = a;
    rd_i = 1'b1;
    cyc(1);
    rd_i = 1'b0;
    chk(rdata_o, e);
    cyc(1);
  endtask

  // Holds the comparators for n cycles, then lets the result settle.
  task automatic oc(input logic hi, input logic lo, input int n);
    oc_hi_i = hi;
    oc_lo_i = lo;
    cyc(n);
    oc_hi_i = 1'b0;
    oc_lo_i = 1'b0;
    cyc(2);
  endtask

  // Closing report shared by the main sequence and the watchdog.
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog: the sequence needs a few thousand cycles at most.
  initial begin
    #100us;
    fails++;
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    rd(MDPC_OFS_OCP, 8'h10);
    rd(MDPC_OFS_RECT, 8'h00);
    rd(MDPC_OFS_REG, 8'h00);
    chk({6'h0, cfg_o.filter_time}, 8'h01);
    // Every code of the multi-bit fields, seen once the write has landed.
    for (int i = 0; i < 4; i++) begin
      wr(MDPC_OFS_RECT, 8'(i));
      chk({6'h0, cfg_o.gain}, 8'(i));
      wr(MDPC_OFS_REG, 8'(i << 1));
      chk({6'h0, cfg_o.voltage}, 8'(i));
      wr(MDPC_OFS_OCP, 8'(i << 4));
      chk({6'h0, cfg_o.filter_time}, 8'(i));
      wr(MDPC_OFS_OCP, 8'(i));
      chk({6'h0, cfg_o.response}, 8'(i));
    end
    wr(MDPC_OFS_OCP, 8'hCC);
    chk({standby_o, cfg_o.shutoff, cfg_o.cycle_clear, cfg_o.retry_long,
         cfg_o.threshold_hi}, 8'h1F);
    wr(MDPC_OFS_OCP, 8'h00);
    chk({standby_o, cfg_o.shutoff, cfg_o.cycle_clear, cfg_o.retry_long,
         cfg_o.threshold_hi}, 8'h00);
    wr(MDPC_OFS_RECT, 8'h4C);
    chk({cfg_o.recirc_diode, cfg_o.async_rect, cfg_o.sync_rect},
        8'h07);
    wr(MDPC_OFS_RECT, 8'hB3);
    chk({cfg_o.recirc_diode, cfg_o.async_rect, cfg_o.sync_rect},
        8'h00);
    rd(MDPC_OFS_RECT, 8'hB3);
    // Top two regulator bits are read-only zero.
    wr(MDPC_OFS_REG, 8'hFF);
    chk({cfg_o.seq_off, cfg_o.cap_low, cfg_o.voltage, cfg_o.reg_off},
        8'h1F);
    rd(MDPC_OFS_REG, 8'h3F);
    wr(MDPC_OFS_REG, 8'h20);
    chk({cfg_o.seq_off, cfg_o.cap_low, cfg_o.voltage, cfg_o.reg_off},
        8'h00);
    rd(MDPC_OFS_REG, 8'h20);
    rd(4'hF, 8'h00);
    // Locked bank ignores writes until the unlock pattern.
    wr(MDPC_OFS_LOCK, 8'h06);
    chk({7'h0, locked_o}, 8'h01);
    rd(MDPC_OFS_LOCK, 8'h01);
    wr(MDPC_OFS_OCP, 8'h55);
    rd(MDPC_OFS_OCP, 8'h00);
    wr(MDPC_OFS_LOCK, 8'h03);
    chk({7'h0, locked_o}, 8'h00);
    wr(MDPC_OFS_OCP, 8'h55);
    rd(MDPC_OFS_OCP, 8'h55);
    // Latched fault, shortest filter: 30 cycles are a glitch, 60 are not.
    wr(MDPC_OFS_OCP, 8'h00);
    oc(1'b0, 1'b1, 30);
    chk({6'h0, oc_shutdown_o, oc_report_o}, 8'h00);
    oc(1'b0, 1'b1, 60);
    chk({6'h0, oc_shutdown_o, oc_report_o}, 8'h03);
    pwm_i = 1'b1;
    cyc(RL);
    pwm_i = 1'b0;
    chk({7'h0, oc_shutdown_o}, 8'h01);
    wr(MDPC_OFS_CLR, 8'h01);
    chk({6'h0, oc_shutdown_o, oc_report_o}, 8'h00);
    rd(MDPC_OFS_CLR, 8'h00);
    // High trip level ignores the low comparator alone.
    wr(MDPC_OFS_OCP, 8'h04);
    oc(1'b0, 1'b1, 60);
    chk({7'h0, oc_shutdown_o}, 8'h00);
    oc(1'b1, 1'b1, 60);
    chk({7'h0, oc_shutdown_o}, 8'h01);
    wr(MDPC_OFS_CLR, 8'h01);
    // A PWM rising edge clears the fault when per-cycle clearing is on.
    wr(MDPC_OFS_OCP, 8'h40);
    oc(1'b0, 1'b1, 60);
    chk({7'h0, oc_shutdown_o}, 8'h01);
    pwm_i = 1'b1;
    cyc(2);
    pwm_i = 1'b0;
    chk({7'h0, oc_shutdown_o}, 8'h00);
    wr(MDPC_OFS_CLR, 8'h01);
    // Retrying fault with the short and then the long wait.
    wr(MDPC_OFS_OCP, 8'h01);
    oc(1'b0, 1'b1, 42);
    chk({7'h0, oc_shutdown_o}, 8'h01);
    cyc(RS + 5);
    chk({7'h0, oc_shutdown_o}, 8'h00);
    wr(MDPC_OFS_OCP, 8'h09);
    oc(1'b0, 1'b1, 42);
    cyc(RS + 5);
    chk({7'h0, oc_shutdown_o}, 8'h01);
    cyc(RL);
    chk({7'h0, oc_shutdown_o}, 8'h00);
    // Report-only and ignore responses.
    wr(MDPC_OFS_CLR, 8'h01);
    wr(MDPC_OFS_OCP, 8'h02);
    oc(1'b0, 1'b1, 45);
    chk({6'h0, oc_shutdown_o, oc_report_o}, 8'h01);
    wr(MDPC_OFS_CLR, 8'h01);
    wr(MDPC_OFS_OCP, 8'h03);
    oc(1'b0, 1'b1, 45);
    chk({6'h0, oc_shutdown_o, oc_report_o}, 8'h00);
    // Longest filter: 300 cycles pass, 330 trip.
    wr(MDPC_OFS_OCP, 8'h30);
    oc(1'b0, 1'b1, 300);
    chk({7'h0, oc_shutdown_o}, 8'h00);
    oc(1'b0, 1'b1, 330);
    chk({7'h0, oc_shutdown_o}, 8'h01);
    summarize();
  end
endmodule
`default_nettype wire
